// file: nfh_pkg.sv
// Purpose: Shared constants and types for the NAND flash host port controller
// Assumes: 125 MHz clock, byte-wide asynchronous flash pins
// Notes: Pin timing counts derive from nanosecond figures below
package nfh_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int STROBE_LOW_NS = 24;
  localparam int STROBE_HIGH_NS = 24;
  localparam int READ_CYCLE_NS = 50;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLE_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_WAIT_NS = 200;
  localparam int BUSY_WAIT_CYC = (BUSY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_BYTES = 2112;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [2:0] FULL_ADDR_CYCLES = 3'h5;
  localparam logic [2:0] ROW_ADDR_CYCLES = 3'h3;
  localparam logic [2:0] ROW_FIRST = 3'h2;
  localparam logic [3:0] COL_HI_MASK = 4'hF;

  typedef enum logic [2:0] {
    NFH_OP_READ = 3'h0,
    NFH_OP_PROGRAM = 3'h1,
    NFH_OP_ERASE = 3'h2,
    NFH_OP_RESET = 3'h3,
    NFH_OP_STATUS = 3'h4
  } nfh_op_e;

  typedef struct packed {
    nfh_op_e op;
    logic [11:0] column;
    logic [16:0] row;
    logic [11:0] count;
  } nfh_req_s;

  typedef struct packed {
    logic cmd_latch;
    logic addr_latch;
    logic chip_select_n;
    logic write_strobe_n;
    logic output_strobe_n;
    logic program_guard_n;
  } nfh_ctl_s;
endpackage : nfh_pkg

// file: nfh_fifo.sv
// Purpose: Parameterised valid/ready FIFO for the data path
// Assumes: Single clock, synchronous active-low reset
// Notes: Full and empty are exact; no fall-through
`timescale 1ns/1ps
`default_nettype none
module nfh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;
  logic push;
  logic pop;

  assign in_ready_out = (fill != (AW+1)'(DEPTH));
  assign out_valid_out = (fill != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : nfh_fifo
`default_nettype wire

// file: nfh_host.sv
// Purpose: Host-side controller driving a NAND flash over its byte-wide pins
// Assumes: Pull-up on ready/busy supplied by the board, pins asynchronous to clk_in
// Notes: One request at a time; write data drained from and read data filled into FIFOs
`timescale 1ns/1ps
`default_nettype none
module nfh_host (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire nfh_pkg::nfh_req_s req_in,
  input wire logic guard_enable_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [7:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [7:0] rd_data_out,
  output logic done_out,
  output logic [7:0] status_out,
  output logic [7:0] io_out,
  output logic io_oe_n_out,
  input wire logic [7:0] io_in,
  output nfh_pkg::nfh_ctl_s ctl_out,
  input wire logic ready_busy_n_in
);
  import nfh_pkg::*;

  typedef enum logic [3:0] {
    NFH_IDLE = 4'h0,
    NFH_CMD1 = 4'h1,
    NFH_ADDR = 4'h3,
    NFH_DATA = 4'h2,
    NFH_CMD2 = 4'h6,
    NFH_WAIT = 4'h7,
    NFH_READ = 4'h5,
    NFH_DONE = 4'h4
  } nfh_state_e;

  nfh_state_e state;
  nfh_req_s req;
  logic [2:0] rb_sync;
  logic rb_ready;
  logic [7:0] phase;
  logic strobe_low;
  logic [2:0] addr_idx;
  logic [11:0] remaining;
  logic [7:0] cur_byte;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [7:0] fifo_rd_data;
  logic in_push;
  logic in_ready;
  logic [7:0] in_data;
  logic [7:0] wr_q_data;
  logic wr_q_valid;
  logic wr_q_pop;
  logic is_read;
  logic is_cmd_only;

  nfh_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(wr_valid_in),
    .in_ready_out(wr_ready_out),
    .in_data_in(wr_data_in),
    .out_valid_out(wr_q_valid),
    .out_ready_in(wr_q_pop),
    .out_data_out(wr_q_data)
  );

  nfh_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(in_push),
    .in_ready_out(in_ready),
    .in_data_in(in_data),
    .out_valid_out(fifo_rd_valid),
    .out_ready_in(fifo_rd_ready),
    .out_data_out(fifo_rd_data)
  );

  // Output register stage so rd_valid_out and rd_data_out come from flops
  assign fifo_rd_ready = !rd_valid_out || rd_ready_in;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= 8'h00;
    end else if (fifo_rd_ready) begin
      rd_valid_out <= fifo_rd_valid;
      rd_data_out <= fifo_rd_data;
    end
  end

  // Three-stage synchroniser; change accepted once stages two and three agree
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rb_sync <= 3'h0;
      rb_ready <= 1'b0;
    end else begin
      rb_sync <= {rb_sync[1:0], ready_busy_n_in};
      if (rb_sync[1] == rb_sync[2]) begin
        rb_ready <= rb_sync[2];
      end
    end
  end

  assign is_read = (req.op == NFH_OP_READ) || (req.op == NFH_OP_STATUS);
  assign is_cmd_only = (req.op == NFH_OP_RESET) || (req.op == NFH_OP_STATUS);
  // Sample read byte at end of strobe low time, stall strobe when FIFO full
  // Status bytes go to status_out only, never into the read stream
  assign in_push = (state == NFH_READ) && strobe_low && (phase == 8'(READ_CYCLE_CYC / 2 - 1)) && !is_cmd_only;
  assign in_data = io_in;
  // Pop as the strobe rises, so the byte stands on the pins for the whole cycle
  assign wr_q_pop = (state == NFH_DATA) && strobe_low && (phase == 8'(STROBE_LOW_CYC - 1));

  always_comb begin
    cur_byte = 8'h00;
    case (state)
      NFH_CMD1: begin
        case (req.op)
          NFH_OP_READ: cur_byte = CMD_READ_SETUP;
          NFH_OP_PROGRAM: cur_byte = CMD_PROG_SETUP;
          NFH_OP_ERASE: cur_byte = CMD_ERASE_SETUP;
          NFH_OP_RESET: cur_byte = CMD_RESET;
          default: cur_byte = CMD_STATUS;
        endcase
      end
      NFH_ADDR: begin
        case (addr_idx)
          3'h0: cur_byte = req.column[7:0];
          3'h1: cur_byte = {COL_HI_MASK & 4'h0, req.column[11:8]};
          3'h2: cur_byte = req.row[7:0];
          3'h3: cur_byte = req.row[15:8];
          default: cur_byte = {7'h00, req.row[16]};
        endcase
      end
      NFH_CMD2: begin
        case (req.op)
          NFH_OP_READ: cur_byte = CMD_READ_CONFIRM;
          NFH_OP_PROGRAM: cur_byte = CMD_PROG_CONFIRM;
          default: cur_byte = CMD_ERASE_CONFIRM;
        endcase
      end
      default: cur_byte = wr_q_data;
    endcase
  end

  // Sequencer: each write cycle is strobe high then low, timed by phase
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= NFH_IDLE;
      req <= '0;
      phase <= 8'h00;
      strobe_low <= 1'b0;
      addr_idx <= 3'h0;
      remaining <= 12'h000;
      req_ready_out <= 1'b0;
      done_out <= 1'b0;
      status_out <= 8'h00;
      io_out <= 8'h00;
      io_oe_n_out <= 1'b1;
      ctl_out <= '{cmd_latch: 1'b0, addr_latch: 1'b0, chip_select_n: 1'b1,
                   write_strobe_n: 1'b1, output_strobe_n: 1'b1, program_guard_n: 1'b0};
    end else begin
      done_out <= 1'b0;
      // Ready follows last cycle's rb_ready; a request is lost if rb_ready falls in the cycle it arrives
      req_ready_out <= (state == NFH_IDLE) && !req_valid_in && rb_ready;
      ctl_out.program_guard_n <= guard_enable_in;
      case (state)
        NFH_IDLE: begin
          ctl_out.chip_select_n <= 1'b1;
          io_oe_n_out <= 1'b1;
          if (req_valid_in && req_ready_out && rb_ready) begin
            req <= req_in;
            state <= NFH_CMD1;
            phase <= 8'h00;
            strobe_low <= 1'b0;
            req_ready_out <= 1'b0;
            addr_idx <= (req_in.op == NFH_OP_ERASE) ? ROW_FIRST : 3'h0;
            remaining <= req_in.count;
          end
        end
        NFH_CMD1, NFH_ADDR, NFH_CMD2, NFH_DATA: begin
          ctl_out.chip_select_n <= 1'b0;
          ctl_out.cmd_latch <= (state == NFH_CMD1) || (state == NFH_CMD2);
          ctl_out.addr_latch <= (state == NFH_ADDR);
          io_out <= cur_byte;
          io_oe_n_out <= 1'b0;
          if (!strobe_low) begin
            if (phase == 8'(STROBE_HIGH_CYC)) begin
              // Setup settled; drop the strobe unless write data is missing
              if (state != NFH_DATA || wr_q_valid) begin
                strobe_low <= 1'b1;
                ctl_out.write_strobe_n <= 1'b0;
                phase <= 8'h00;
              end
            end else begin
              phase <= phase + 8'h01;
            end
          end else if (phase == 8'(STROBE_LOW_CYC - 1)) begin
            strobe_low <= 1'b0;
            ctl_out.write_strobe_n <= 1'b1; // Rising edge latches the byte
            phase <= 8'h00;
            case (state)
              NFH_CMD1: begin
                if (is_cmd_only) begin
                  state <= (req.op == NFH_OP_STATUS) ? NFH_READ : NFH_WAIT;
                  remaining <= 12'h001;
                end else begin
                  state <= NFH_ADDR;
                end
              end
              NFH_ADDR: begin
                addr_idx <= addr_idx + 3'h1;
                if (addr_idx == FULL_ADDR_CYCLES - 3'h1) begin
                  state <= (req.op == NFH_OP_PROGRAM && remaining != 12'h000) ? NFH_DATA : NFH_CMD2;
                end
              end
              NFH_DATA: begin
                remaining <= remaining - 12'h001;
                if (remaining == 12'h001) begin
                  state <= NFH_CMD2;
                end
              end
              default: state <= NFH_WAIT;
            endcase
          end else begin
            phase <= phase + 8'h01;
          end
        end
        NFH_WAIT: begin
          // Release the bus and give the busy line time to fall first
          ctl_out.cmd_latch <= 1'b0;
          ctl_out.addr_latch <= 1'b0;
          io_oe_n_out <= 1'b1;
          if (phase != 8'(BUSY_WAIT_CYC)) begin
            phase <= phase + 8'h01;
          end else if (rb_ready) begin
            phase <= 8'h00;
            state <= is_read ? NFH_READ : NFH_DONE;
          end
        end
        NFH_READ: begin
          io_oe_n_out <= 1'b1;
          ctl_out.cmd_latch <= 1'b0;
          if (!strobe_low) begin
            if (remaining == 12'h000) begin
              state <= NFH_DONE;
            end else if (phase == 8'(READ_CYCLE_CYC / 2) && (in_ready || is_cmd_only)) begin
              strobe_low <= 1'b1;
              ctl_out.output_strobe_n <= 1'b0;
              phase <= 8'h00;
            end else if (phase != 8'(READ_CYCLE_CYC / 2)) begin
              phase <= phase + 8'h01;
            end
          end else if (phase == 8'(READ_CYCLE_CYC / 2 - 1)) begin
            strobe_low <= 1'b0;
            ctl_out.output_strobe_n <= 1'b1;
            phase <= 8'h00;
            remaining <= remaining - 12'h001;
            if (is_cmd_only) begin
              status_out <= io_in;
            end
          end else begin
            phase <= phase + 8'h01;
          end
        end
        NFH_DONE: begin
          done_out <= 1'b1;
          ctl_out.chip_select_n <= 1'b1;
          state <= NFH_IDLE;
        end
        default: state <= NFH_IDLE;
      endcase
    end
  end
endmodule : nfh_host
`default_nettype wire

// file: nfh_host_chk.sv
// Purpose: Pin-level assertions for the flash host port
// Assumes: Sees only the nfh_host ports
// Notes: Bound from the testbench top
`timescale 1ns/1ps
`default_nettype none
module nfh_host_chk (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic guard_enable_in,
  input wire logic done_out,
  input wire logic [7:0] io_out,
  input wire logic io_oe_n_out,
  input wire nfh_pkg::nfh_ctl_s ctl_out,
  input wire logic ready_busy_n_in
);
  import nfh_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence we_low3;
    !ctl_out.write_strobe_n [*3] ##1 ctl_out.write_strobe_n;
  endsequence
  a_rst_pins: assert property (disable iff (1'b0)
    !rst_n_in |=> io_oe_n_out && ctl_out.chip_select_n && ctl_out.write_strobe_n
    && ctl_out.output_strobe_n && !ctl_out.program_guard_n) else $error("pins not idle in reset");
  a_guard_follow: assert property ($past(rst_n_in) |->
    ctl_out.program_guard_n == $past(guard_enable_in)) else $error("guard pin lags");
  a_drive_sel: assert property (!io_oe_n_out |->
    ctl_out.output_strobe_n && !ctl_out.chip_select_n) else $error("bus driven while reading");
  a_latch_excl: assert property (!(ctl_out.cmd_latch && ctl_out.addr_latch))
    else $error("both latches high");
  a_strobe_sel: assert property (!(ctl_out.write_strobe_n && ctl_out.output_strobe_n) |->
    !ctl_out.chip_select_n) else $error("strobe while deselected");
  a_we_pulse: assert property ($fell(ctl_out.write_strobe_n) |-> we_low3)
    else $error("write strobe width");
  a_we_hold: assert property (!ctl_out.write_strobe_n || $rose(ctl_out.write_strobe_n) |->
    $stable(io_out) && $stable(ctl_out.cmd_latch) && $stable(ctl_out.addr_latch)) else $error("byte moved");
  a_read_space: assert property ($fell(ctl_out.output_strobe_n) |=>
    !$fell(ctl_out.output_strobe_n) [*6]) else $error("read cycle under 50 ns");
  a_busy_wait: assert property ((!ready_busy_n_in) [*4] |-> ctl_out.output_strobe_n)
    else $error("read while busy");
  a_done_once: assert property (done_out |=> !done_out) else $error("done too long");
endmodule : nfh_host_chk
`default_nettype wire

// file: nfh_flash_model.sv
// Purpose: Behavioural flash device on the far side
// Assumes: Host keeps strobe widths; busy times shortened
// Notes: Pull-up on ready/busy lives in the testbench
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model #(
  parameter int BUSY_NS = 800,
  parameter logic [7:0] STAT = 8'hE0
) (
  input wire nfh_pkg::nfh_ctl_s ctl_in,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic rb_low_out
);
  import nfh_pkg::*;
  logic [7:0] page_reg [PAGE_BYTES];
  logic [7:0] arr [int];
  logic [7:0] setup, dout;
  logic [7:0] adr [5];
  logic stat;
  int na, col, row;
  initial begin
    rb_low_out = 1'b0;
    {setup, dout, stat, na, col, row} = '0;
  end
  // Released bus shows the inverse, never a stale byte
  assign io_out = (!ctl_in.chip_select_n && !ctl_in.output_strobe_n) ? dout : ~dout;
  task automatic busy(input int ns);
    rb_low_out = 1'b1;
    fork begin #(ns); rb_low_out = 1'b0; end join_none
  endtask : busy
  task automatic cmd(input logic [7:0] c);
    if (rb_low_out && c != CMD_RESET && c != CMD_STATUS) return;
    stat = (c == CMD_STATUS);
    if (c == CMD_READ_SETUP || c == CMD_PROG_SETUP || c == CMD_ERASE_SETUP) begin
      setup = c; na = 0;
      if (c == CMD_PROG_SETUP) foreach (page_reg[i]) page_reg[i] = 8'hFF;
    end else if (c == CMD_READ_CONFIRM && setup == CMD_READ_SETUP) begin
      foreach (page_reg[i]) page_reg[i] = arr.exists(row * 4096 + i) ? arr[row * 4096 + i] : 8'hFF;
      busy(BUSY_NS);
    end else if (c == CMD_PROG_CONFIRM && setup == CMD_PROG_SETUP) begin
      if (ctl_in.program_guard_n) foreach (page_reg[i]) arr[row * 4096 + i] = page_reg[i];
      busy(BUSY_NS);
    end else if (c == CMD_ERASE_CONFIRM && setup == CMD_ERASE_SETUP) begin
      row = {adr[2][0], adr[1], adr[0]};
      if (ctl_in.program_guard_n) for (int p = 0; p < 64; p++)
        for (int i = 0; i < PAGE_BYTES; i++) arr.delete(((row & ~63) + p) * 4096 + i);
      busy(BUSY_NS);
    end else if (c == CMD_RESET) begin
      setup = 8'h00; busy(BUSY_NS / 4);
    end
  endtask : cmd
  always @(posedge ctl_in.write_strobe_n) begin
    if (ctl_in.chip_select_n) ;
    else if (ctl_in.cmd_latch) cmd(io_in);
    else if (rb_low_out) ;
    else if (ctl_in.addr_latch) begin
      if (na < ((setup == CMD_ERASE_SETUP) ? 3 : 5)) adr[na] = io_in;
      na++;
      col = {adr[1][3:0], adr[0]};
      row = {adr[4][0], adr[3], adr[2]};
    end else begin
      if (col < PAGE_BYTES) page_reg[col] = io_in;
      col++;
    end
  end
  always @(negedge ctl_in.output_strobe_n) begin
    if (!ctl_in.chip_select_n) begin
      if (stat) dout = STAT;
      else begin dout = (col < PAGE_BYTES) ? page_reg[col] : 8'hFF; col++; end
    end
  end
endmodule : nfh_flash_model
`default_nettype wire

// file: nfh_host_tb_top.sv
// Purpose: Self-checking bench for the flash host port
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Flash busy shortened to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module nfh_host_tb_top;
  import nfh_pkg::*;
  localparam logic [7:0] STAT = 8'hE0;
  localparam logic [16:0] ROW = 17'h10045;
  logic clk_in = 0, rst_n_in = 0, req_valid_in = 0, guard_enable_in = 1, wr_valid_in = 0, rd_ready_in = 0;
  nfh_req_s req_in = '0;
  logic [7:0] wr_data_in = 8'h00;
  logic req_ready_out, wr_ready_out, rd_valid_out, done_out, io_oe_n_out, rb_low;
  logic [7:0] rd_data_out, status_out, io_out, dev_io;
  nfh_ctl_s ctl_out;
  wire logic [7:0] io_in;
  wire logic ready_busy_n_in;
  int fails = 0, checked = 0;
  assign io_in = io_oe_n_out ? dev_io : io_out;
  assign ready_busy_n_in = ~rb_low;
  always #4 clk_in = ~clk_in;
  nfh_host dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_in(req_in), .guard_enable_in(guard_enable_in),
    .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out), .wr_data_in(wr_data_in),
    .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in), .rd_data_out(rd_data_out),
    .done_out(done_out), .status_out(status_out), .io_out(io_out), .io_oe_n_out(io_oe_n_out),
    .io_in(io_in), .ctl_out(ctl_out), .ready_busy_n_in(ready_busy_n_in));
  nfh_flash_model #(.STAT(STAT)) flash_u (.ctl_in(ctl_out), .io_in(io_in), .io_out(dev_io),
    .rb_low_out(rb_low));
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick
  task automatic end_of_test();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin fails++; $display("Error at %0t: got %0h expected %0h", $time, got, exp); end
  endtask : check
  task automatic bound(inout int n);
    n++;
    if (n > 20000) begin fails++; end_of_test(); end
  endtask : bound
  task automatic run_req(input nfh_op_e op, input logic [11:0] col, input logic [11:0] cnt);
    int n;
    n = 0;
    while (req_ready_out !== 1'b1) begin tick(); bound(n); end
    req_in = '{op, col, ROW, cnt};
    req_valid_in = 1'b1;
    tick();
    req_valid_in = 1'b0;
    while (done_out !== 1'b1) begin tick(); bound(n); end
  endtask : run_req
  task automatic drain(input logic [7:0] base, input logic [7:0] step);
    int n, got;
    {n, got} = '0;
    repeat (20) tick(); // Reader stalls first: rd_ready_in held low for 20 cycles
    rd_ready_in = 1'b1;
    while (got < FIFO_DEPTH) begin
      if (rd_valid_out === 1'b1) begin check(rd_data_out, base + step * got); got++; end
      tick();
      bound(n);
    end
    rd_ready_in = 1'b0;
  endtask : drain
  task automatic sc_prog(input logic [7:0] base);
    int n;
    n = 0;
    wr_valid_in = 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      wr_data_in = base + i;
      while (wr_ready_out !== 1'b1) begin tick(); bound(n); end
      tick();
    end
    wr_valid_in = 1'b0;
    check({7'h00, wr_ready_out}, 8'h00);
    run_req(NFH_OP_PROGRAM, 12'h003, FIFO_DEPTH);
  endtask : sc_prog
  task automatic sc_read(input logic [7:0] base, input logic [7:0] step);
    fork
      run_req(NFH_OP_READ, 12'h003, FIFO_DEPTH);
      drain(base, step);
    join
  endtask : sc_read
  task automatic sc_idle();
    check({6'h00, ctl_out.chip_select_n, io_oe_n_out}, 8'h03);
  endtask : sc_idle
  task automatic sc_misc();
    run_req(NFH_OP_STATUS, 12'h000, 12'h000);
    check(status_out, STAT);
    run_req(NFH_OP_RESET, 12'h000, 12'h000);
    check({7'h00, ctl_out.chip_select_n}, 8'h01);
  endtask : sc_misc
  initial begin
    repeat (10) tick();
    rst_n_in = 1'b1;
    tick();
    sc_idle();
    sc_prog(8'hA0);
    sc_read(8'hA0, 8'h01);
    run_req(NFH_OP_ERASE, 12'h000, 12'h000);
    sc_read(8'hFF, 8'h00);
    guard_enable_in = 1'b0;
    sc_prog(8'h50);
    guard_enable_in = 1'b1;
    sc_read(8'hFF, 8'h00);
    sc_misc();
    end_of_test();
  end
endmodule : nfh_host_tb_top
bind nfh_host nfh_host_chk chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .guard_enable_in(guard_enable_in),
  .done_out(done_out), .io_out(io_out), .io_oe_n_out(io_oe_n_out), .ctl_out(ctl_out),
  .ready_busy_n_in(ready_busy_n_in));
`default_nettype wire
